// file: verilog/sbo_relay_pkg.sv
// package for the select-before-operate relay output block
// assumes one 100 MHz clock and plain-port control from the cpu side
package sbo_relay_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_MHZ         = 100;
	localparam int unsigned BLINK_HALF_MS   = 250;
	localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * 1000 * CLK_MHZ;
	localparam int unsigned CHECK_US        = 1;
	localparam int unsigned CHECK_CYC       = CHECK_US * CLK_MHZ;

	// ****************************************
	// reset values and switch codes
	// ****************************************
	localparam logic [1:0] SW_SOFT    = 2'h1; // sw1 on, sw2 off
	localparam logic [1:0] SW_INHIBIT = 2'h3; // both on
	localparam logic       RST_OUT    = 1'h0;

	typedef enum logic [1:0] {
		INH_OFF,
		INH_SOFT,
		INH_ON
	} inhibit_mode_t;

	// per-output fail-safe and mask configuration
	typedef struct packed {
		logic keep_last_value;
		logic predefined_value;
		logic mask;
	} out_cfg_t;

	// select request from the cpu
	typedef struct packed {
		logic       valid;
		logic [2:0] index;
		logic       value;
	} sel_req_t;

endpackage

// file: verilog/select_before_operate_relay_output.sv
// select-before-operate control for eight relay outputs, two relays each
// assumes relay back indications and supply sense arrive asynchronously
`timescale 1ns/1ps

module select_before_operate_relay_output #(
	parameter int unsigned N_OUT    = 8,
	parameter int unsigned BLINK_CYC = sbo_relay_pkg::BLINK_HALF_CYC
) (
	// clock and reset
	input  wire logic                              clk,
	input  wire logic                              nrst,
	// cpu commands
	input  wire sbo_relay_pkg::sel_req_t           select_req,
	input  wire logic                              deselect,
	input  wire logic [N_OUT-1:0]                  out_value,
	input  wire sbo_relay_pkg::out_cfg_t [N_OUT-1:0] out_cfg,
	input  wire logic                              prog_running,
	input  wire logic                              cpu_link_ok,
	input  wire logic                              freeze,
	input  wire logic                              sleep,
	input  wire logic                              site_inhibit_en,
	input  wire logic                              module_fault,
	// switch and supply pins
	input  wire logic [1:0]                        inhibit_mode_switch,
	input  wire logic                              inhibit_input_closed,
	input  wire logic                              controlled_relay_supply,
	// relay back indications, a/b relay per output
	input  wire logic [2*N_OUT-1:0]                select_back,
	input  wire logic [2*N_OUT-1:0]                contact_back,
	// relay drive
	output logic [2*N_OUT-1:0]                     relay_select,
	output logic                                   operate_en,
	output logic [2*N_OUT-1:0]                     relay_energise,
	// status to cpu
	output logic [2*N_OUT-1:0]                     select_back_status,
	output logic [2*N_OUT-1:0]                     contact_back_status,
	output logic                                   inhibited,
	output logic                                   select_error,
	output logic                                   select_busy,
	output logic [N_OUT-1:0]                       position_mismatch,
	output logic                                   failure_status,
	output logic                                   error_led,
	output logic                                   controlled_supply_led,
	output logic                                   sleeping
);

	// ****************************************
	// elaboration checks
	// ****************************************
	// the select index is three bits wide and the check counter is
	// sixteen, so the output count is pinned rather than left free;
	// a blink divider of one would toggle the led every clock, and zero would wrap the compare
	initial begin
		if (N_OUT != 8)
			$error("select_before_operate_relay_output serves exactly eight outputs");
		if (BLINK_CYC < 2)
			$error("BLINK_CYC must be at least two");
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	// every pin that comes from outside the clock domain is gathered
	// into one vector so all share the same two-stage synchroniser;
	// the cost is two cycles of lag on every back indication, which
	// the select check and mismatch logic already allow for
	// hazard: only the second stage may be read, the first can be
	// metastable for part of a cycle after a pin edge
	localparam int SW = 4 + 4 * N_OUT;
	logic [SW-1:0] pin_s1_r;
	logic [SW-1:0] pin_s2_r;
	wire  [SW-1:0] pin_raw = {inhibit_mode_switch, inhibit_input_closed,
		controlled_relay_supply, select_back, contact_back};

	// two stages before any logic looks at a pin
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end

	// slices of the synchronised vector, in the order packed above
	// contact indications sit lowest, switch bits highest
	wire [2*N_OUT-1:0] cont_s = pin_s2_r[2*N_OUT-1:0];
	wire [2*N_OUT-1:0] selb_s = pin_s2_r[4*N_OUT-1:2*N_OUT];
	wire               supply_s = pin_s2_r[4*N_OUT];
	wire               inh_closed_s = pin_s2_r[4*N_OUT+1];
	wire [1:0]         sw_s = pin_s2_r[4*N_OUT+3:4*N_OUT+2];

	// ****************************************
	// inhibit decode
	// ****************************************
	// the switch has four positions but only three meanings: two of
	// them leave inhibiting off, one hands the choice to software and
	// the last forces it on; any code not matched falls to off, which
	// is the safe reading when a switch contact is half made
	function automatic sbo_relay_pkg::inhibit_mode_t decode_sw(input logic [1:0] s);
		if (s == sbo_relay_pkg::SW_INHIBIT)
			return sbo_relay_pkg::INH_ON;
		else if (s == sbo_relay_pkg::SW_SOFT)
			return sbo_relay_pkg::INH_SOFT;
		else
			return sbo_relay_pkg::INH_OFF;
	endfunction

	// switch selects mode; soft mode follows site configuration
	wire sbo_relay_pkg::inhibit_mode_t inh_mode = decode_sw(sw_s);
	wire inh_enabled = (inh_mode == sbo_relay_pkg::INH_ON) ||
		((inh_mode == sbo_relay_pkg::INH_SOFT) && site_inhibit_en);
	// with inhibiting enabled, an open inhibit input or missing controlled supply stops the coils
	wire inh_active = inh_enabled && (!inh_closed_s || !supply_s);
	// sleep and fault both send the sequencer back to idle and freeze the logical state;
	// no relay is driven while either holds
	wire active = !sleep && !module_fault;

	// ****************************************
	// logical output values
	// ****************************************
	// each output has a logical state kept here; priority from high to
	// low is freeze, fail-safe, mask, then the program's own value
	// limitation: keep-last in fail-safe simply holds this register, so
	// a value written just before the link drops is the one kept
	logic [N_OUT-1:0] out_state_r;
	logic [N_OUT-1:0] out_nxt;
	wire failsafe = !prog_running || !cpu_link_ok;

	// fail-safe, mask and freeze priority per output
	genvar g;
	generate
		for (g = 0; g < N_OUT; g++) begin : g_out
			wire fs_val = out_cfg[g].keep_last_value ? out_state_r[g] :
				out_cfg[g].predefined_value;
			wire run_val = out_cfg[g].mask ? out_cfg[g].predefined_value :
				out_value[g];
			assign out_nxt[g] = freeze ? out_state_r[g] :
				(failsafe ? fs_val : run_val);
		end
	endgenerate

	// frozen while inhibited so the state stays put until supply returns;
	// trade-off: program writes made during the inhibit are lost rather
	// than queued, so the program must rewrite after supply returns
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			out_state_r <= '0;
		else if (active && !inh_active)
			out_state_r <= out_nxt;
	end

	// ****************************************
	// select before operate sequence
	// ****************************************
	// idle: nothing selected, operate low
	// select: relays of one output selected, waiting for the select
	//   indication to show exactly that pair and nothing else
	// operate: indication confirmed, coils may be energised
	// any loss of the confirmed indication in operate drops straight
	// back to idle with the error flag raised, so a relay that was
	// selected by a wiring fault can never stay energised
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SELECT,
		ST_OPERATE
	} sbo_state_t;

	sbo_state_t       state_r;
	logic [2:0]       sel_idx_r;
	logic             sel_val_r;
	logic [15:0]      chk_cnt_r;
	logic             sel_err_r;

	// the pair wanted for the chosen output; the whole vector is
	// compared so a stray relay anywhere else also blocks operate
	wire [2*N_OUT-1:0] want_sel = (2*N_OUT)'(2'h3) << {sel_idx_r, 1'h0};
	wire sel_ok = (selb_s == want_sel);
	wire chk_done = (chk_cnt_r == 16'(sbo_relay_pkg::CHECK_CYC));
	// requests are only looked at in idle, so a second select while
	// one output is held is dropped without a trace
	wire take_sel = select_req.valid && (state_r == ST_IDLE);

	// select, wait for matching indication, then operate
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r   <= ST_IDLE;
			sel_idx_r <= 3'h0;
			sel_val_r <= 1'h0;
			chk_cnt_r <= 16'h0000;
			sel_err_r <= 1'h0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					chk_cnt_r <= 16'h0000;
					if (take_sel && active) begin
						sel_idx_r <= select_req.index;
						sel_val_r <= select_req.value;
						sel_err_r <= 1'h0;
						state_r   <= ST_SELECT;
					end
				end
				ST_SELECT: begin
					if (!active || deselect)
						state_r <= ST_IDLE;
					else if (sel_ok)
						state_r <= ST_OPERATE;
					else if (chk_done) begin
						sel_err_r <= 1'h1;
						state_r   <= ST_IDLE;
					end else
						chk_cnt_r <= chk_cnt_r + 16'h0001;
				end
				ST_OPERATE: begin
					if (!active || deselect || !sel_ok) begin
						sel_err_r <= !sel_ok;
						state_r   <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// relay drive
	// ****************************************
	// selection follows the state directly; operate additionally needs
	// the value to be one, no inhibit and the supply present, and each
	// coil is only driven where its own select indication is seen, so
	// a relay that dropped out is not energised blind
	wire [2*N_OUT-1:0] sel_nxt = (state_r == ST_IDLE) ? '0 : want_sel;
	wire op_nxt = (state_r == ST_OPERATE) && sel_val_r && !inh_active
		&& supply_s;
	wire [2*N_OUT-1:0] en_nxt = op_nxt ? (sel_nxt & selb_s) : '0;

	// ****************************************
	// status and leds
	// ****************************************
	// the led blink runs free from reset; it is only shown while the
	// supply is controlled and absent, so its phase does not matter
	logic [31:0] blink_cnt_r;
	logic        blink_r;
	wire blink_wrap = (blink_cnt_r == 32'(BLINK_CYC - 1));

	// blink divider for the supply led
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			blink_cnt_r <= 32'h00000000;
			blink_r     <= 1'h0;
		end else if (blink_wrap) begin
			blink_cnt_r <= 32'h00000000;
			blink_r     <= !blink_r;
		end else
			blink_cnt_r <= blink_cnt_r + 32'h00000001;
	end

	// off when the supply is not under control, steady when controlled
	// and present, blinking when controlled and missing
	wire led_nxt = !inh_enabled ? 1'h0 : (supply_s ? 1'h1 : blink_r);
	wire [N_OUT-1:0] mism;
	generate
		for (g = 0; g < N_OUT; g++) begin : g_mis
			// the output reads as on only when both contacts are closed, and that must agree with the logical state
			assign mism[g] = !inh_active && active &&
				((cont_s[2*g+1:2*g] == 2'h3) != out_state_r[g]);
		end
	endgenerate

	// all outputs registered so nothing at the pins can glitch while
	// the decode above settles; the price is one cycle of latency on
	// every status bit, which the cpu side never notices
	// the status copies of the indications are the synchronised pins,
	// not the drive, so the program sees what the relays really did
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			relay_select          <= '0;
			operate_en            <= 1'h0;
			relay_energise        <= '0;
			select_back_status    <= '0;
			contact_back_status   <= '0;
			inhibited             <= 1'h0;
			select_error          <= 1'h0;
			select_busy           <= 1'h0;
			position_mismatch     <= '0;
			failure_status        <= 1'h0;
			error_led             <= 1'h0;
			controlled_supply_led <= 1'h0;
			sleeping              <= 1'h0;
		end else begin
			relay_select          <= sel_nxt;
			operate_en            <= op_nxt;
			relay_energise        <= en_nxt;
			select_back_status    <= selb_s;
			contact_back_status   <= cont_s;
			inhibited             <= inh_active;
			select_error          <= sel_err_r;
			select_busy           <= (state_r != ST_IDLE);
			position_mismatch     <= mism;
			failure_status        <= module_fault;
			error_led             <= module_fault;
			controlled_supply_led <= led_nxt;
			sleeping              <= sleep;
		end
	end

endmodule

// file: verification/sbo_relay_checker.sv
// concurrent checks on the relay output block ports
// assumes a bind onto the top module, one clock domain
`timescale 1ns/1ps
module sbo_relay_checker #(
	parameter int unsigned N_OUT = 8
) (
	// clock, reset
	input wire logic                     clk,
	input wire logic                     nrst,
	// cpu side
	input wire sbo_relay_pkg::sel_req_t  select_req,
	input wire logic                     deselect,
	input wire logic                     sleep,
	input wire logic                     module_fault,
	// pins
	input wire logic [1:0]               inhibit_mode_switch,
	input wire logic                     controlled_relay_supply,
	// outputs
	input wire logic [2*N_OUT-1:0]       relay_select,
	input wire logic                     operate_en,
	input wire logic [2*N_OUT-1:0]       relay_energise,
	input wire logic                     select_busy,
	input wire logic                     inhibited,
	input wire logic                     failure_status,
	input wire logic                     error_led,
	input wire logic                     controlled_supply_led,
	input wire logic                     sleeping
);
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// a relay of each pair
	localparam logic [2*N_OUT-1:0] A_BITS = {N_OUT{2'h1}};

	idle_no_op_a: assert property (!select_busy |-> !operate_en)
		else $error("operate while idle");
	energise_op_a: assert property (relay_energise != '0 |->
		operate_en && (relay_energise & ~relay_select) == '0)
		else $error("energise without operate");
	supply_off_a: assert property (!controlled_relay_supply [*4] |-> relay_energise == '0)
		else $error("energised without supply");
	pair_sel_a: assert property (((relay_select & A_BITS) << 1) == (relay_select & ~A_BITS))
		else $error("relay pair split");
	one_out_a: assert property ($countones(relay_select) <= 2)
		else $error("two outputs selected");
	op_sel_a: assert property (operate_en |-> $countones(relay_select) == 2)
		else $error("operate without selection");
	sel_take_a: assert property (select_req.valid && !select_busy && !sleep && !module_fault
		&& !deselect |-> ##[1:3] select_busy)
		else $error("select not taken");
	inh_off_a: assert property ((inhibit_mode_switch[0] == 1'h0) [*4] |->
		!inhibited && !controlled_supply_led)
		else $error("inhibit with switch off");
	fault_led_a: assert property (module_fault [*3] |-> error_led && failure_status)
		else $error("fault not shown");
	sleep_mode_a: assert property (sleep [*3] |-> sleeping && !operate_en)
		else $error("sleep not entered");

	// main scenarios
	cover property (operate_en && relay_energise != '0);
	cover property ($rose(controlled_supply_led));
	cover property ($fell(select_busy) && !operate_en);
endmodule

// file: verification/relay_model.sv
// relays with select and contact back indications
// assumes the block's relay drive pins, same clock
`timescale 1ns/1ps
module relay_model #(
	parameter int unsigned N_OUT = 8
) (
	// drive in
	input wire logic                 clk,
	input wire logic [2*N_OUT-1:0]   relay_select,
	input wire logic [2*N_OUT-1:0]   relay_energise,
	input wire logic                 bad,
	// back indications
	output logic [2*N_OUT-1:0]       select_back,
	output logic [2*N_OUT-1:0]       contact_back
);
	logic [2*N_OUT-1:0] s1_r;
	logic [2*N_OUT-1:0] c1_r;
	initial {s1_r, c1_r, select_back, contact_back} = '0;
	// two-cycle relay lag; a wiring fault flips the select indication pair of output 0
	always @(posedge clk) begin
		s1_r <= relay_select;
		c1_r <= relay_energise;
		select_back <= bad ? s1_r ^ 2'h3 : s1_r;
		contact_back <= c1_r;
	end
endmodule

// file: verification/select_before_operate_relay_output_tb_top.sv
// self-checking bench for the relay output block
// assumes the relay model on the far side, checker bound
`timescale 1ns/1ps
module select_before_operate_relay_output_tb_top;
	localparam int unsigned N_OUT = 8;
	typedef struct packed {
		logic [1:0] sw;
		logic       site, closed, sup, inh;
		logic [1:0] led;
	} row_t;
	logic clk = 1'h0, nrst = 1'h0, deselect = 1'h0, site = 1'h1, closed = 1'h1, sup = 1'h1;
	logic sleep = 1'h0, fault = 1'h0, bad = 1'h0, operate_en, inhibited, select_error;
	logic select_busy, failure_status, error_led, controlled_supply_led, sleeping;
	logic [1:0] sw = 2'h0;
	logic frz = 1'h0, led_prev;
	logic [7:0] pm;
	logic [15:0] sb, cb, relay_select, relay_energise, sb_st, cb_st;
	sbo_relay_pkg::sel_req_t sreq = '0;
	int num_errors = 0, checks_done = 0, t;
	row_t rows [7] = '{'{2'h0,1,0,0,0,0}, '{2'h2,1,0,0,0,0}, '{2'h3,1,1,1,0,1},
		'{2'h3,1,0,1,1,1}, '{2'h3,1,1,0,1,2}, '{2'h1,1,0,1,1,1}, '{2'h1,0,0,1,0,0}};

	always #5 clk = ~clk;

	select_before_operate_relay_output #(.N_OUT(N_OUT), .BLINK_CYC(4))
	select_before_operate_relay_output_i (.clk(clk), .nrst(nrst), .select_req(sreq),
		.deselect(deselect), .out_value(8'h00), .out_cfg('0), .prog_running(1'h1),
		.cpu_link_ok(1'h1), .freeze(frz), .sleep(sleep), .site_inhibit_en(site),
		.module_fault(fault), .inhibit_mode_switch(sw), .inhibit_input_closed(closed),
		.controlled_relay_supply(sup), .select_back(sb), .contact_back(cb),
		.relay_select(relay_select), .operate_en(operate_en), .relay_energise(relay_energise),
		.select_back_status(sb_st), .contact_back_status(cb_st), .inhibited(inhibited),
		.select_error(select_error), .select_busy(select_busy), .position_mismatch(pm),
		.failure_status(failure_status), .error_led(error_led),
		.controlled_supply_led(controlled_supply_led), .sleeping(sleeping));

	relay_model #(.N_OUT(N_OUT)) relay_model_i (.clk(clk), .relay_select(relay_select),
		.relay_energise(relay_energise), .bad(bad), .select_back(sb), .contact_back(cb));

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// watchdog, far beyond the expected run of under a thousand cycles
	initial begin
		#200000;
		num_errors++;
		finish_test();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		cyc(16);
		nrst = 1'h1;
		chk("relay_select", relay_select, 16'h0000);
		chk("operate_en", 16'(operate_en), 16'h0000);
		// switch, site and supply rows; led blinks at four-cycle halves
		foreach (rows[i]) begin
			{sw, site, closed, sup} = {rows[i].sw, rows[i].site, rows[i].closed, rows[i].sup};
			cyc(6);
			chk("inhibited", 16'(inhibited), 16'(rows[i].inh));
			t = 0;
			repeat (20) begin
				led_prev = controlled_supply_led;
				cyc(1);
				t += int'(controlled_supply_led !== led_prev);
			end
			chk("supply_led", (t > 1) ? 16'h2 : 16'(controlled_supply_led), 16'(rows[i].led));
		end
		{sw, closed, sup} = {2'h0, 1'h1, 1'h1};
		cyc(4);
		sreq = '{1'h1, 3'h3, 1'h1};
		repeat (10) if (!select_busy) cyc(1);
		sreq.valid = 1'h0;
		chk("relay_select", relay_select, 16'h00C0);
		chk("operate_early", 16'(operate_en), 16'h0000);
		repeat (20) if (!operate_en) cyc(1);
		chk("relay_energise", relay_energise, 16'h00C0);
		sreq = '{1'h1, 3'h5, 1'h1};
		cyc(5);
		sreq.valid = 1'h0;
		chk("second_select", relay_select, 16'h00C0);
		cyc(4);
		chk("select_back", sb_st, 16'h00C0);
		chk("contact_back", cb_st, 16'h00C0);
		chk("mismatch", 16'(pm), 16'h0008);
		sup = 1'h0;
		cyc(5);
		chk("supply_off", relay_energise, 16'h0000);
		{sup, deselect} = 2'h3;
		cyc(5);
		chk("deselect", relay_select, 16'h0000);
		{deselect, bad} = 2'h1;
		sreq = '{1'h1, 3'h2, 1'h1};
		repeat (10) if (!select_busy) cyc(1);
		sreq.valid = 1'h0;
		repeat (130) if (!select_error) cyc(1);
		chk("select_error", {select_error, operate_en, relay_select[13:0]}, 16'h8000);
		{bad, fault} = 2'h1;
		cyc(5);
		chk("fault", {error_led, failure_status}, 16'h3);
		{fault, sleep} = 2'h1;
		cyc(5);
		chk("sleeping", 16'(sleeping), 16'h1);
		finish_test();
	end
endmodule

bind select_before_operate_relay_output sbo_relay_checker #(.N_OUT(N_OUT)) sbo_relay_checker_i (
	.clk(clk), .nrst(nrst), .select_req(select_req), .deselect(deselect), .sleep(sleep),
	.module_fault(module_fault), .inhibit_mode_switch(inhibit_mode_switch),
	.controlled_relay_supply(controlled_relay_supply), .relay_select(relay_select),
	.operate_en(operate_en), .relay_energise(relay_energise), .select_busy(select_busy),
	.inhibited(inhibited), .failure_status(failure_status), .error_led(error_led),
	.controlled_supply_led(controlled_supply_led), .sleeping(sleeping));
